// file: pkg/dcrc_map.svh
// register map of the channel range configuration bank
// assumes an 8-bit register port of the SPI slave front end
// ============================================================
// Notes on behaviour
// - bit 7 enables channel 0 sink, resets 1
// - output enable bits active low, reset 0
// - enables 5,4,3,2,1,0 at bits 5,4,3,2,1,0; bit6 reserved
// - channel 0 mode 00 source, 01 sink, 10 both
// - scaling six bits in 7:2, reset zero
// - channel 1 mode 01/10/11, resets 10
// - channel 2 mode bit 0, bit 1 reserved
// - channel 3 mode bit 0, bit 1 reserved
// - channel 4 mode bit 0, bit 1 reserved
// - channel 1 range resets 0x02, others 0x00
// - enable register at 0x14, resets 0x80
`ifndef DCRC_MAP_SVH
`define DCRC_MAP_SVH
`define DCRC_ADDR_ENABLES    8'h14
`define DCRC_ADDR_RANGE0     8'h15
`define DCRC_ADDR_RANGE1     8'h16
`define DCRC_ADDR_RANGE2     8'h17
`define DCRC_ADDR_RANGE3     8'h18
`define DCRC_ADDR_RANGE4     8'h19
`define DCRC_RST_ENABLES     8'h80
`define DCRC_RST_RANGE0      8'h00
`define DCRC_RST_RANGE1      8'h02
`define DCRC_RST_RANGE_N     8'h00
`define DCRC_MASK_ENABLES    8'hBF
`define DCRC_MASK_RANGE_WIDE 8'hFF
`define DCRC_MASK_RANGE_BIT  8'hFD
`define DCRC_POS_SINK        7
`define DCRC_SCALE_LSB       2
`endif

// file: pkg/dcrc_pkg.sv
// types of the channel range configuration bank
// assumes dcrc_map.svh supplies the numbers
package dcrc_pkg;
   typedef logic [7:0] dcrc_byte_t;
   typedef logic [5:0] dcrc_scale_t;
   typedef enum logic [1:0] {
      DCRC_CH0_SOURCE, DCRC_CH0_SINK, DCRC_CH0_BOTH, DCRC_CH0_UNDEF
   } dcrc_chan0_range_select_t;
   typedef enum logic [1:0] {
      DCRC_CH1_UNDEF, DCRC_CH1_LOW_HEAD, DCRC_CH1_LOW_NOISE, DCRC_CH1_WIDE
   } dcrc_chan1_range_select_t;
endpackage : dcrc_pkg

// file: logic/dcrc_regs.sv
// channel enable and output range registers, 0x14 to 0x19
// assumes the SPI front end gives one-cycle write strobes and a byte address
`include "dcrc_map.svh"
module dcrc_regs
   import dcrc_pkg::*;
(
   // clock and reset
   input  wire logic           clk,
   input  wire logic           sys_rst,
   // register port
   input  wire logic [7:0]     reg_addr,
   input  wire logic           reg_wr,
   input  wire logic [7:0]     reg_wdata,
   output      logic [7:0]     reg_rdata,
   output      logic           reg_hit,
   // channel controls
   output      logic           chan0_sink_generator_on,
   output      logic [5:0]     chan_output_on_n,
   output      dcrc_chan0_range_select_t chan0_range_select,
   output      dcrc_chan1_range_select_t chan1_range_select,
   output      logic [2:0]     chan_range_select_bit,
   output      logic [29:0]    chan_range_scale
);
   // ============================================================
   // storage
   dcrc_byte_t enables;
   dcrc_byte_t ranges [5];

   function automatic logic [7:0] dcrc_mask(input logic [2:0] idx);
      dcrc_mask = (idx < 3'd2) ? `DCRC_MASK_RANGE_WIDE : `DCRC_MASK_RANGE_BIT;
   endfunction : dcrc_mask

   // ============================================================
   // decode
   wire        hit_en   = (reg_addr == `DCRC_ADDR_ENABLES);
   wire        hit_rng  = (reg_addr >= `DCRC_ADDR_RANGE0) && (reg_addr <= `DCRC_ADDR_RANGE4);
   wire [7:0]  rel      = reg_addr - `DCRC_ADDR_RANGE0;
   wire [2:0]  rng_idx  = rel[2:0];
   // reserved bits drop on write so they always read zero
   wire [7:0]  wr_en_v  = reg_wdata & `DCRC_MASK_ENABLES;
   wire [7:0]  wr_rng_v = reg_wdata & dcrc_mask(rng_idx);
   wire [7:0]  rd_v     = hit_en ? enables : (hit_rng ? ranges[rng_idx] : 8'h00);

   // ============================================================
   // write strikes and stored reserved bits
   wire        wr_enables  = reg_wr && hit_en;
   wire        wr_range0   = reg_wr && (reg_addr == `DCRC_ADDR_RANGE0);
   wire        wr_range1   = reg_wr && (reg_addr == `DCRC_ADDR_RANGE1);
   wire        wr_range2   = reg_wr && (reg_addr == `DCRC_ADDR_RANGE2);
   wire        wr_range3   = reg_wr && (reg_addr == `DCRC_ADDR_RANGE3);
   wire        wr_range4   = reg_wr && (reg_addr == `DCRC_ADDR_RANGE4);
   // kept visible so the checks can prove reserved bits never store
   wire        res6_stored = enables[6];
   wire [2:0]  res1_stored = {ranges[4][1], ranges[3][1], ranges[2][1]};

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         enables <= `DCRC_RST_ENABLES;
      end else if (reg_wr && hit_en) begin
         enables <= wr_en_v;
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         ranges[0] <= `DCRC_RST_RANGE0;
      end else if (wr_range0) begin
         ranges[0] <= wr_rng_v;
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         ranges[1] <= `DCRC_RST_RANGE1;
      end else if (wr_range1) begin
         ranges[1] <= wr_rng_v;
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         ranges[2] <= `DCRC_RST_RANGE_N;
      end else if (wr_range2) begin
         ranges[2] <= wr_rng_v;
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         ranges[3] <= `DCRC_RST_RANGE_N;
      end else if (wr_range3) begin
         ranges[3] <= wr_rng_v;
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         ranges[4] <= `DCRC_RST_RANGE_N;
      end else if (wr_range4) begin
         ranges[4] <= wr_rng_v;
      end
   end

   // ============================================================
   // registered outputs
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         reg_rdata <= 8'h00;
         reg_hit   <= 1'b0;
      end else begin
         reg_rdata <= rd_v;
         reg_hit   <= hit_en | hit_rng;
      end
   end

   // control outputs track storage one cycle later
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         chan0_sink_generator_on <= 1'b1;
         chan_output_on_n        <= 6'h00;
         chan0_range_select      <= DCRC_CH0_SOURCE;
         chan1_range_select      <= DCRC_CH1_LOW_NOISE;
         chan_range_select_bit   <= 3'h0;
         chan_range_scale        <= 30'h0000_0000;
      end else begin
         chan0_sink_generator_on <= enables[`DCRC_POS_SINK];
         chan_output_on_n        <= enables[5:0];
         chan0_range_select      <= dcrc_chan0_range_select_t'(ranges[0][1:0]);
         chan1_range_select      <= dcrc_chan1_range_select_t'(ranges[1][1:0]);
         chan_range_select_bit   <= {ranges[4][0], ranges[3][0], ranges[2][0]};
         chan_range_scale        <= {ranges[4][7:2], ranges[3][7:2], ranges[2][7:2],
                                     ranges[1][7:2], ranges[0][7:2]};
      end
   end

   // ============================================================
   // checks
   AST_SINK_RESET: assert property (@(posedge clk)
      $fell(sys_rst)
      |-> chan0_sink_generator_on)
      else $error("sink enable wrong after reset");

   AST_SINK_FOLLOW: assert property (@(posedge clk)
      disable iff (sys_rst)
      wr_enables
      |=> ##1 chan0_sink_generator_on == $past(reg_wdata[7], 2))
      else $error("sink enable does not follow write");

   AST_ON_N_RESET: assert property (@(posedge clk)
      $fell(sys_rst)
      |-> chan_output_on_n == 6'h00)
      else $error("output enables wrong after reset");

   AST_ON_N_FOLLOW: assert property (@(posedge clk)
      disable iff (sys_rst)
      wr_enables
      |=> ##1 chan_output_on_n == $past(reg_wdata[5:0], 2))
      else $error("output enables do not follow write");

   AST_RES6_ZERO: assert property (@(posedge clk)
      disable iff (sys_rst)
      reg_hit && $past(hit_en)
      |-> !reg_rdata[6])
      else $error("reserved bit 6 read nonzero");

   AST_RES6_STORE: assert property (@(posedge clk)
      disable iff (sys_rst)
      wr_enables && reg_wdata[6]
      |=> !res6_stored)
      else $error("reserved bit 6 stored");

   AST_CH4_BIT4: assert property (@(posedge clk)
      disable iff (sys_rst)
      wr_enables
      |=> ##1 chan_output_on_n[4] == $past(reg_wdata[4], 2))
      else $error("channel 4 enable not at bit 4");

   AST_CH0_BIT0: assert property (@(posedge clk)
      disable iff (sys_rst)
      wr_enables
      |=> ##1 chan_output_on_n[0] == $past(reg_wdata[0], 2))
      else $error("channel 0 enable not at bit 0");

   AST_CHAN0_RANGE_SELECT: assert property (@(posedge clk)
      disable iff (sys_rst)
      wr_range0
      |=> ##1 chan0_range_select == dcrc_chan0_range_select_t'($past(reg_wdata[1:0], 2)))
      else $error("channel 0 mode not stored");

   AST_CH0_RESET: assert property (@(posedge clk)
      $fell(sys_rst)
      |-> chan0_range_select == DCRC_CH0_SOURCE)
      else $error("channel 0 mode reset wrong");

   AST_SCALE0: assert property (@(posedge clk)
      disable iff (sys_rst)
      wr_range0
      |=> ##1 chan_range_scale[5:0] == $past(reg_wdata[7:2], 2))
      else $error("channel 0 scale not stored");

   AST_SCALE1: assert property (@(posedge clk)
      disable iff (sys_rst)
      wr_range1
      |=> ##1 chan_range_scale[11:6] == $past(reg_wdata[7:2], 2))
      else $error("channel 1 scale not stored");

   AST_SCALE2: assert property (@(posedge clk)
      disable iff (sys_rst)
      wr_range2
      |=> ##1 chan_range_scale[17:12] == $past(reg_wdata[7:2], 2))
      else $error("channel 2 scale not stored");

   AST_SCALE3: assert property (@(posedge clk)
      disable iff (sys_rst)
      wr_range3
      |=> ##1 chan_range_scale[23:18] == $past(reg_wdata[7:2], 2))
      else $error("channel 3 scale not stored");

   AST_SCALE4: assert property (@(posedge clk)
      disable iff (sys_rst)
      wr_range4
      |=> ##1 chan_range_scale[29:24] == $past(reg_wdata[7:2], 2))
      else $error("channel 4 scale not stored");

   AST_SCALE_RESET: assert property (@(posedge clk)
      $fell(sys_rst)
      |-> chan_range_scale == 30'h0000_0000 && chan_range_select_bit == 3'h0)
      else $error("scale or mode bits wrong after reset");

   AST_CHAN1_RANGE_SELECT: assert property (@(posedge clk)
      disable iff (sys_rst)
      wr_range1
      |=> ##1 chan1_range_select == dcrc_chan1_range_select_t'($past(reg_wdata[1:0], 2)))
      else $error("channel 1 mode not stored");

   AST_CH1_RESET: assert property (@(posedge clk)
      $fell(sys_rst)
      |-> chan1_range_select == DCRC_CH1_LOW_NOISE)
      else $error("channel 1 mode reset wrong");

   AST_BIT2: assert property (@(posedge clk)
      disable iff (sys_rst)
      wr_range2
      |=> ##1 chan_range_select_bit[0] == $past(reg_wdata[0], 2))
      else $error("channel 2 mode bit not stored");

   AST_BIT3: assert property (@(posedge clk)
      disable iff (sys_rst)
      wr_range3
      |=> ##1 chan_range_select_bit[1] == $past(reg_wdata[0], 2))
      else $error("channel 3 mode bit not stored");

   AST_BIT4: assert property (@(posedge clk)
      disable iff (sys_rst)
      wr_range4
      |=> ##1 chan_range_select_bit[2] == $past(reg_wdata[0], 2))
      else $error("channel 4 mode bit not stored");

   AST_RES1_ZERO: assert property (@(posedge clk)
      disable iff (sys_rst)
      reg_hit && $past(hit_rng) && $past(rng_idx) >= 3'd2
      |-> !reg_rdata[1])
      else $error("reserved bit 1 read nonzero");

   AST_RES1_STORE: assert property (@(posedge clk)
      disable iff (sys_rst)
      (wr_range2 || wr_range3 || wr_range4) && reg_wdata[1]
      |=> res1_stored == 3'h0)
      else $error("reserved bit 1 stored");

   AST_RANGE_RESET: assert property (@(posedge clk)
      $fell(sys_rst)
      |-> ranges[0] == `DCRC_RST_RANGE0 && ranges[1] == `DCRC_RST_RANGE1)
      else $error("range registers reset wrong");

   AST_EN_ADDR: assert property (@(posedge clk)
      disable iff (sys_rst)
      reg_addr == `DCRC_ADDR_ENABLES
      |=> reg_hit && reg_rdata == $past(enables))
      else $error("enable register readback wrong");

   AST_EN_RESET: assert property (@(posedge clk)
      $fell(sys_rst)
      |-> enables == `DCRC_RST_ENABLES)
      else $error("enable register reset wrong");

   AST_MISS_ZERO: assert property (@(posedge clk)
      disable iff (sys_rst)
      !hit_en && !hit_rng
      |=> !reg_hit && reg_rdata == 8'h00)
      else $error("unmapped address answered");

   AST_HIT_RANGE: assert property (@(posedge clk)
      disable iff (sys_rst)
      hit_rng
      |=> reg_hit)
      else $error("range address not answered");

   AST_OLD_ON_WRITE: assert property (@(posedge clk)
      disable iff (sys_rst)
      wr_range1 && reg_wdata != ranges[1]
      |=> reg_rdata == $past(ranges[1]))
      else $error("read during write not old value");

   // ============================================================
   // coverage
   COV_EN_WRITE:  cover property (@(posedge clk) reg_wr && hit_en);
   COV_CH0_SINK:  cover property (@(posedge clk) chan0_range_select == DCRC_CH0_SINK);
   COV_CH1_WIDE:  cover property (@(posedge clk) chan1_range_select == DCRC_CH1_WIDE);
   COV_MISS_READ: cover property (@(posedge clk) !reg_hit && !sys_rst);
   COV_BITS_SET:  cover property (@(posedge clk) chan_range_select_bit == 3'h7);
endmodule : dcrc_regs

// file: verif/dcrc_host.sv
// host model that writes and reads the range bank register port
// assumes the bench calls its tasks from one process only
module dcrc_host (
   // clock
   input  wire logic       clk,
   // register port
   output      logic [7:0] reg_addr,
   output      logic       reg_wr,
   output      logic [7:0] reg_wdata,
   input  wire logic [7:0] reg_rdata,
   input  wire logic       reg_hit
);
   timeunit 1ns;
   timeprecision 1ns;
   initial begin
      reg_addr  = 8'h00;
      reg_wr    = 1'b0;
      reg_wdata = 8'h00;
   end
   // released data shows the inverse so a stale byte cannot pass
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      reg_addr  <= a;
      reg_wr    <= 1'b1;
      reg_wdata <= d;
      @(posedge clk);
      reg_wr    <= 1'b0;
      reg_wdata <= ~d;
   endtask : wr
   task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic h);
      @(posedge clk);
      reg_addr <= a;
      @(posedge clk);
      @(negedge clk);
      d = reg_rdata;
      h = reg_hit;
   endtask : rd
endmodule : dcrc_host

// file: verif/dcrc_regs_tb.sv
// self-checking bench of the channel enable and range registers
// assumes dcrc_host drives the port and reset is synchronous
`include "dcrc_map.svh"
module dcrc_regs_tb;
   import dcrc_pkg::*;
   timeunit 1ns;
   timeprecision 1ns;
   logic           clk = 1'b0;
   logic           sys_rst = 1'b1;
   logic [7:0]     reg_addr, reg_wdata, reg_rdata, rd_val;
   logic           reg_wr, reg_hit, sink_on, rd_hit;
   logic [5:0]     on_n;
   dcrc_chan0_range_select_t m0;
   dcrc_chan1_range_select_t m1;
   logic [2:0]     mbit;
   logic [29:0]    scale;
   int             fails = 0;
   int             num_checks = 0;
   always #25 clk = ~clk;
   dcrc_host host (.clk(clk), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
      .reg_rdata(reg_rdata), .reg_hit(reg_hit));
   dcrc_regs dut (.clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wr(reg_wr),
      .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_hit(reg_hit),
      .chan0_sink_generator_on(sink_on), .chan_output_on_n(on_n), .chan0_range_select(m0),
      .chan1_range_select(m1), .chan_range_select_bit(mbit), .chan_range_scale(scale));
   // ============================================================
   // helpers and scenarios
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         fails++;
         $display("ERROR %s expected %h seen %h", nm, exp, seen);
      end
   endtask : chk
   task automatic rchk(input logic [7:0] a, input logic [7:0] e, input logic h);
      host.rd(a, rd_val, rd_hit);
      chk("reg_rdata", rd_val, e);
      chk("reg_hit", rd_hit, h);
   endtask : rchk
   task automatic t_reset;
      rchk(`DCRC_ADDR_ENABLES, `DCRC_RST_ENABLES, 1'b1);
      for (int a = 8'h15; a <= 8'h19; a++) begin
         rchk(8'(a), (a == 8'h16) ? `DCRC_RST_RANGE1 : `DCRC_RST_RANGE_N, 1'b1);
      end
      chk("sink_on", sink_on, 1);
      chk("on_n", on_n, 0);
      chk("m1", m1, 2);
      chk("m0", m0, 0);
      chk("mbit", mbit, 0);
      chk("scale", scale, 0);
   endtask : t_reset
   task automatic t_enables;
      for (int i = 0; i < 8; i++) begin
         host.wr(`DCRC_ADDR_ENABLES, 8'(1 << i));
         rchk(`DCRC_ADDR_ENABLES, 8'(1 << i) & `DCRC_MASK_ENABLES, 1'b1);
         chk("on_n", on_n, (1 << i) & 8'h3F);
         chk("sink_on", sink_on, i == 7);
      end
   endtask : t_enables
   task automatic t_wide;
      for (int c = 0; c < 4; c++) begin
         // nonzero scale only while sourcing
         if (c < 3) host.wr(`DCRC_ADDR_RANGE0, {(c == 0) ? 6'h3F : 6'h00, 2'(c)});
         host.wr(`DCRC_ADDR_RANGE1, {6'h15, 2'(c == 0 ? 2 : c)});
         rchk(`DCRC_ADDR_RANGE1, {6'h15, 2'(c == 0 ? 2 : c)}, 1'b1);
         if (c < 3) chk("m0", {m0, scale[5:0]}, {2'(c), (c == 0) ? 6'h3F : 6'h00});
         chk("m1", {m1, scale[11:6]}, {2'(c == 0 ? 2 : c), 6'h15});
      end
   endtask : t_wide
   task automatic t_narrow;
      for (int n = 0; n < 6; n++) begin
         host.wr(8'(8'h17 + n % 3), (n < 3) ? 8'hFF : 8'h00);
         rchk(8'(8'h17 + n % 3), (n < 3) ? `DCRC_MASK_RANGE_BIT : 8'h00, 1'b1);
         chk("mbit", mbit[n % 3], n < 3);
         chk("scale", scale[12 + 6 * (n % 3) +: 6], (n < 3) ? 6'h3F : 6'h00);
      end
   endtask : t_narrow
   task automatic t_undef;
      host.wr(`DCRC_ADDR_RANGE0, 8'h03);
      host.wr(`DCRC_ADDR_RANGE1, 8'h00);
      rchk(`DCRC_ADDR_RANGE0, 8'h03, 1'b1);
      rchk(`DCRC_ADDR_RANGE1, 8'h00, 1'b1);
      chk("m0", m0, 3);
      chk("m1", m1, 0);
   endtask : t_undef
   task automatic t_rereset;
      host.wr(`DCRC_ADDR_RANGE1, 8'hFF);
      @(posedge clk);
      sys_rst <= 1'b1;
      repeat (2) @(posedge clk);
      sys_rst <= 1'b0;
      t_reset();
   endtask : t_rereset
   task automatic t_unmapped;
      host.wr(8'h1A, 8'hFF);
      host.wr(8'h13, 8'hFF);
      rchk(8'h1A, 8'h00, 1'b0);
      rchk(8'h13, 8'h00, 1'b0);
      rchk(`DCRC_ADDR_ENABLES, 8'h80, 1'b1);
   endtask : t_unmapped
   task automatic final_report;
      if (fails == 0 && num_checks > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask : final_report
   initial begin
      repeat (2) @(posedge clk);
      sys_rst <= 1'b0;
      t_reset();
      t_enables();
      t_wide();
      t_narrow();
      t_undef();
      t_enables();
      t_rereset();
      t_unmapped();
      final_report();
   end
endmodule : dcrc_regs_tb
